/* File: dv/plm_board.sv */
`timescale 1ns/1ps
module plm_board (
    input  logic [15:0] drv_i,     // Board level on each pin
    input  logic [15:0] pin_out_i, // Block pin data
    input  logic [15:0] pin_oe_i,  // Block driver enable
    output logic [15:0] pin_o      // Resolved wire level
);
    // Block wins where it drives; board elsewhere
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drv_i);
endmodule // plm_board

/* File: dv/plm_lb_assertions.sv */
`timescale 1ns/1ps
module plm_lb_checker (
    input logic                     clock_i,
    input logic                     rst_n_i,
    input plm_pkg::apb_req_t        apb_i,
    input plm_pkg::apb_rsp_t        apb_o,
    input logic [plm_pkg::N_IO-1:0] io_oe_o
);
    import plm_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Access phase of any transfer
    sequence s_acc;
        apb_i.psel && apb_i.penable;
    endsequence
    property p_rdy; apb_i.psel |-> apb_o.pready; endproperty
    property p_idle; !apb_i.penable |-> !apb_o.pslverr; endproperty
    property p_ro;
        s_acc ##0 (apb_i.pwrite && apb_i.paddr == ADDR_OUT) |-> apb_o.pslverr;
    endproperty
    property p_unal;
        s_acc ##0 (apb_i.paddr[1:0] != 2'h0) |-> apb_o.pslverr;
    endproperty
    property p_unmap;
        s_acc ##0 (apb_i.paddr >= ADDR_END) |-> apb_o.pslverr;
    endproperty
    property p_sig;
        s_acc ##0 (apb_i.paddr == ADDR_SIG) |-> !apb_o.pslverr;
    endproperty
    // Read data must hold in the first idle cycle after the access
    property p_hold; s_acc ##1 !apb_i.psel |-> $stable(apb_o.prdata);
    endproperty
    property p_stop;
        s_acc ##0 (apb_i.pwrite && apb_i.paddr == ADDR_CTRL
            && !apb_i.pwdata[CTRL_RUN]) |=> io_oe_o == '0;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("pready low");
    a_idle: assert property (p_idle)
        else $error("error outside access");
    a_ro: assert property (p_ro)
        else $error("write to status accepted");
    a_unal: assert property (p_unal)
        else $error("unaligned accepted");
    a_unmap: assert property (p_unmap)
        else $error("unmapped accepted");
    a_sig: assert property (p_sig)
        else $error("signature refused");
    a_hold: assert property (p_hold)
        else $error("read data moved");
    a_stop: assert property (p_stop)
        else $error("pin driven while stopped");
endmodule // plm_lb_checker

bind plm_logic_block plm_lb_checker chk_u (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o), .io_oe_o(io_oe_o));

/* File: dv/test_plm_logic_block.sv */
`timescale 1ns/1ps
module test_plm_logic_block;
    import plm_pkg::*;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    apb_req_t apb = '0;
    apb_rsp_t rsp;
    logic [3:0] ded = 4'h0;
    logic [15:0] drv = 16'h0;
    logic [15:0] pin, dout, oe, fbo;
    int bad_count = 0;
    int n_compared = 0;
    always #2 clock_i = ~clock_i;
    plm_logic_block dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .apb_i(apb), .apb_o(rsp), .ded_i(ded), .ext_bus_i({EXT_W{1'h0}}),
        .io_in_i(pin), .io_out_o(dout), .io_oe_o(oe), .fb_o(fbo));
    plm_board brd_u (.drv_i(drv), .pin_out_i(dout), .pin_oe_i(oe),
        .pin_o(pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; a read compares its data with d
    task automatic xf(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic e);
        apb.psel <= 1'h1;
        apb.pwrite <= w;
        apb.paddr <= a;
        apb.pwdata <= d;
        @(posedge clock_i);
        apb.penable <= 1'h1;
        do begin
            @(posedge clock_i);
        end while (rsp.pready !== 1'h1);
        chk({31'h0, rsp.pslverr}, {31'h0, e});
        if (!w) chk(rsp.prdata, d);
        apb.psel <= 1'h0;
        apb.penable <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic tick(input logic [3:0] v, input logic [2:0] exp);
        ded <= v;
        repeat (3) @(posedge clock_i);
        chk({29'h0, fbo[0], pin[0], oe[0]}, {29'h0, exp});
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'h1;
        @(posedge clock_i);
        xf(1'h0, ADDR_CTRL, 32'h0, 1'h0);
        xf(1'h0, ADDR_SIG, 32'h0, 1'h0);
        xf(1'h1, ADDR_SIG, 32'hbeef, 1'h0);
        xf(1'h0, ADDR_SIG, 32'hbeef, 1'h0);
        xf(1'h1, ADDR_OUT, 32'h0, 1'h1);
        xf(1'h1, 12'h006, 32'h0, 1'h1);
        xf(1'h1, ADDR_END, 32'h0, 1'h1);
        // Cell 0: pin follows dedicated input 0, shared clock ded 1
        xf(1'h1, ADDR_CFG, 32'h0, 1'h0);
        xf(1'h1, 12'h4a0, 32'h40007ff8, 1'h0);
        xf(1'h1, 12'h4a4, 32'h405, 1'h0);
        xf(1'h1, 12'h4a8, 32'h1, 1'h0);
        xf(1'h1, ADDR_CTRL, 32'h1, 1'h0);
        tick(4'h1, 3'h7);
        tick(4'h0, 3'h1);
        xf(1'h1, 12'h4a0, 32'h0, 1'h1);
        xf(1'h0, 12'h4a0, 32'h40007ff8, 1'h0);
        // Registered output: only a rising shared clock loads it
        xf(1'h1, ADDR_CTRL, 32'h0, 1'h0);
        xf(1'h1, 12'h4a0, 32'h50007ff8, 1'h0);
        xf(1'h1, ADDR_CTRL, 32'h1, 1'h0);
        tick(4'h1, 3'h5);
        tick(4'h3, 3'h7);
        xf(1'h0, ADDR_OUT, 32'hffffffff, 1'h0);
        tick(4'h0, 3'h3);
        // Latch: open while the shared clock is high
        xf(1'h1, ADDR_CTRL, 32'h0, 1'h0);
        xf(1'h1, 12'h4a0, 32'h50407ff8, 1'h0);
        xf(1'h1, ADDR_CTRL, 32'h1, 1'h0);
        tick(4'h1, 3'h5);
        tick(4'h3, 3'h7);
        tick(4'h1, 3'h7);
        tick(4'h0, 3'h3);
        xf(1'h1, ADDR_CTRL, 32'h2, 1'h0);
        xf(1'h0, 12'h4a0, 32'h0, 1'h0);
        xf(1'h1, 12'h4a0, 32'h0, 1'h1);
        xf(1'h0, ADDR_SIG, 32'hbeef, 1'h0);
        tally_and_finish;
    end
endmodule // test_plm_logic_block

/* File: hw/plm_cfg_mem.sv */
`timescale 1ns/1ps
module plm_cfg_mem #(
    parameter int DEPTH = plm_pkg::CFG_DEPTH,
    parameter int AW    = plm_pkg::CFG_AW,
    parameter int W     = plm_pkg::WORD_W
) (
    input  logic               clock_i,
    input  logic               rst_n_i,
    input  logic               we_i,
    input  logic [AW-1:0]      addr_i,
    input  logic [W-1:0]       wdata_i,
    output logic [W-1:0]       rdata_o,
    output logic [DEPTH*W-1:0] cfg_o
);
    import plm_pkg::*;
    // ****************************************
    // Storage
    // ****************************************
    logic [W-1:0] mem_q [DEPTH]; // Configuration words
    logic         hit;           // Address in range

    assign hit = addr_i < AW'(DEPTH);

    // Write port, cleared to an unused block
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we_i && hit) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= hit ? mem_q[addr_i] : '0;
        end
    end

    // Whole store in parallel for the logic
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            cfg_o[i*W +: W] = mem_q[i];
        end
    end
endmodule // plm_cfg_mem

/* File: hw/plm_logic_block.sv */
`timescale 1ns/1ps
// What this block does
// - Global bus: all pins and feedbacks
// - Switch matrix picks forty bus signals
// - Five ANDed product terms per cell
// - Each term routed to sum or control
// - Up to five terms into OR
// - Cascade chains reach forty product terms
// - Data from XOR, term or pin
// - Storage acts as D, T, JK, SR
// - Latch passes while clock high
// - Shared or term clock, rising edge
// - Low enable term ignores shared edges
// - Clear: shared, term, both, none
// - Preset: term or none
// - Output and feedback registered or not
// - Pin mode: input, output, both
// - Enable from pins, I/Os or cells
// - Input pins keep cell logic usable
// - Inverted foldback term onto regional bus
// - Foldbacks allow twenty-one term sums
// - Signature readable; fuse hides configuration
// - Dedicated inputs serve as shared controls
module plm_logic_block #(
    parameter int EXT_W = plm_pkg::EXT_W
) (
    input  logic                         clock_i,
    input  logic                         rst_n_i,
    input  plm_pkg::apb_req_t            apb_i,
    output plm_pkg::apb_rsp_t            apb_o,
    input  logic [plm_pkg::N_DED-1:0]    ded_i,
    input  logic [EXT_W-1:0]             ext_bus_i,
    input  logic [plm_pkg::N_IO-1:0]     io_in_i,
    output logic [plm_pkg::N_IO-1:0]     io_out_o,
    output logic [plm_pkg::N_IO-1:0]     io_oe_o,
    output logic [plm_pkg::N_MC-1:0]     fb_o
);
    import plm_pkg::*;

    // ****************************************
    // Local sizes
    // ****************************************
    // Everything the switch can pick from
    localparam int GB_W = EXT_W + N_MC + N_IO + N_DED;

    // ****************************************
    // Declarations
    // ****************************************
    logic                    run_q;      // Logic running
    logic                    fuse_q;     // Security fuse
    logic [SIG_W-1:0]        sig_q;      // User signature
    logic [31:0]             prdata_q;   // Read word
    logic                    rd_cfg_q;   // Read from store
    logic                    err_q;      // Error for access
    logic                    setup;      // First bus cycle
    logic                    access;     // Second bus cycle
    logic                    wr_ok;      // Write commits
    regsel_t                 dec_sel;    // Decoded target
    logic [CFG_AW-1:0]       cfg_idx;    // Store word index
    logic                    cfg_we;     // Store write
    logic [31:0]             mem_rdata;  // Store read word
    logic [CFG_DEPTH*32-1:0] cfg;        // Whole store
    logic [GB_W-1:0]         gbus;       // Global bus
    logic [N_SW-1:0]         sw;         // Switch outputs
    logic [N_MC-1:0]         fold;       // Regional bus
    logic [N_MC-1:0]         casc;       // Cascade outputs
    logic [N_MC-1:0]         fb;         // Buried feedbacks
    logic [N_MC-1:0]         mc_out;     // Cell outputs
    logic [N_MC-1:0]         mc_q;       // Storage values
    logic [N_MC-1:0]         oe;         // Chosen enables
    mc_out_t                 res [N_MC]; // Per cell results

    // ****************************************
    // Helper functions
    // ****************************************

    // Register target of a byte address
    function automatic regsel_t decode(
        input logic [ADDR_W-1:0] a
    );
        // Whole aligned words only
        if (a[1:0] != 2'h0) begin
            decode = SEL_BAD;
        end else if (a == ADDR_CTRL) begin
            decode = SEL_CTRL;
        end else if (a == ADDR_SIG) begin
            decode = SEL_SIG;
        end else if (a == ADDR_OUT) begin
            decode = SEL_OUT;
        end else if (a >= ADDR_CFG && a < ADDR_END) begin
            // Store window, one word per step
            decode = SEL_CFG;
        end else begin
            decode = SEL_BAD;
        end
    endfunction

    // Word index inside the store
    function automatic logic [CFG_AW-1:0] word_of(
        input logic [ADDR_W-1:0] a
    );
        logic [ADDR_W-1:0] off;
        // Byte offset from the store base
        off = a - ADDR_CFG;
        word_of = off[CFG_AW+1:2];
    endfunction

    // One control word of a cell
    function automatic logic [31:0] ctl(
        input logic [CFG_DEPTH*32-1:0] c,
        input int                      m,
        input int                      w
    );
        // Cell slices follow the switch words
        ctl = c[(MC_BASE + m*MC_WORDS + w)*32 +: 32];
    endfunction

    // ****************************************
    // Bus phases
    // ****************************************
    // Both phases need psel; penable splits them
    assign setup   = apb_i.psel & ~apb_i.penable;
    assign access  = apb_i.psel & apb_i.penable;
    assign dec_sel = decode(apb_i.paddr);
    assign cfg_idx = word_of(apb_i.paddr);
    // A faulted access changes nothing
    assign wr_ok   = access & apb_i.pwrite & ~err_q;
    // Store is frozen while running or protected
    assign cfg_we  = wr_ok & (dec_sel == SEL_CFG);

    // ****************************************
    // Setup capture: error and read data
    // ****************************************

    // Decided at setup so the access needs no wait
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Quiet bus after reset
            err_q    <= 1'b0;
            rd_cfg_q <= 1'b0;
        end else if (setup) begin
            // Unmapped, read-only, or locked store
            err_q <= (dec_sel == SEL_BAD) ||
                     (apb_i.pwrite && dec_sel == SEL_OUT) ||
                     (apb_i.pwrite && dec_sel == SEL_CFG &&
                      (run_q || fuse_q));
            // Picks the data source for the access
            rd_cfg_q <= (dec_sel == SEL_CFG);
        end
    end

    // Read word for the small registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= '0;
        end else if (setup) begin
            // Captured once; stands all access
            case (dec_sel)
                // Run and fuse state
                SEL_CTRL: prdata_q <= {30'h0, fuse_q, run_q};
                // Always visible, fuse or not
                SEL_SIG:  prdata_q <= {16'h0, sig_q};
                // Live storage and pin values
                SEL_OUT:  prdata_q <= {mc_q, mc_out};
                default:  prdata_q <= '0;
            endcase
        end
    end

    // ****************************************
    // Answer: no wait states
    // ****************************************
    always_comb begin
        // Never stretched: no wait states
        apb_o.pready  = 1'b1;
        apb_o.pslverr = access & err_q;
        // Protected store reads back as zero
        if (rd_cfg_q) begin
            apb_o.prdata = fuse_q ? 32'h0 : mem_rdata;
        end else begin
            // Small registers from their flop
            apb_o.prdata = prdata_q;
        end
    end

    // ****************************************
    // Control, fuse and signature
    // ****************************************

    // Run flag; cells are held cleared while low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Cells idle until software starts them
            run_q <= 1'b0;
        end else if (wr_ok && dec_sel == SEL_CTRL) begin
            // Stopping releases pins at once; cells clear on the next clock
            run_q <= apb_i.pwdata[CTRL_RUN];
        end
    end

    // Fuse only sets; nothing but reset clears it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fuse_q <= 1'b0;
        end else if (wr_ok && dec_sel == SEL_CTRL &&
                     apb_i.pwdata[CTRL_FUSE]) begin
            // Also ends all store access
            fuse_q <= 1'b1;
        end
    end

    // Signature stays writable under the fuse
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sig_q <= SIG_RST;
        end else if (wr_ok && dec_sel == SEL_SIG) begin
            // Upper bits of the word are dropped
            sig_q <= apb_i.pwdata[SIG_W-1:0];
        end
    end

    // ****************************************
    // Configuration store
    // ****************************************
    // Written only while stopped
    // Whole store fans out: area for no waits
    plm_cfg_mem #(
        .DEPTH (CFG_DEPTH),
        .AW    (CFG_AW),
        .W     (WORD_W)
    ) u_cfg (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .we_i    (cfg_we),
        .addr_i  (cfg_idx),
        .wdata_i (apb_i.pwdata),
        .rdata_o (mem_rdata),
        .cfg_o   (cfg)
    );

    // ****************************************
    // Global bus and switch matrix
    // ****************************************

    // Pins, own feedbacks and everyone else's
    // Order fixes the select indices
    assign gbus = {ext_bus_i, fb, io_in_i, ded_i};

    // Each output takes one bus bit by index
    always_comb begin
        for (int i = 0; i < N_SW; i++) begin
            logic [SEL_W-1:0] s;
            // Select from low bits of word i
            s = cfg[(SW_BASE + i)*32 +: SEL_W];
            // Out-of-range index gives a quiet zero
            if (int'(s) < GB_W) begin
                sw[i] = gbus[s];
            end else begin
                sw[i] = 1'b0;
            end
        end
    end

    // ****************************************
    // Macrocells
    // ****************************************
    for (genvar m = 0; m < N_MC; m++) begin : g_mc
        logic [31:0] c1;  // Second control word
        logic        cin; // Cascade from neighbour
        // Clock and clear pins live in word 1
        assign c1 = ctl(cfg, m, 1);
        // Chains restart every CASC_LEN cells
        if (m % CASC_LEN == 0) begin : g_head
            assign cin = 1'b0;
        end else begin : g_link
            assign cin = casc[m-1];
        end
        // Foldbacks widen the sum to 5 plus 16
        plm_macrocell u_mc (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            // Regional bus is shared by all cells
            .pti_i   ({fold, sw}),
            .cfg_i   (cfg[(MC_BASE + m*MC_WORDS)*32 +:
                          MC_WORDS*32]),
            .gclk_i  (ded_i[c1[F_CKPIN +: 2]]),
            .gclr_i  (ded_i[c1[F_CLRPIN +: 2]]),
            .casc_i  (cin),
            .pin_i   (io_in_i[m]),
            .run_i   (run_q),
            .res_o   (res[m])
        );
        assign fold[m]   = res[m].fold;
        assign casc[m]   = res[m].casc;
        // Feedback stays live for input-only pins
        assign fb[m]     = res[m].fb;
        assign mc_out[m] = res[m].out;
        assign mc_q[m]   = res[m].q;
    end

    // ****************************************
    // Output enable and pin mode
    // ****************************************

    // Per cell enable source, then pin mode
    always_comb begin
        for (int m = 0; m < N_MC; m++) begin
            logic [31:0] c0, c1;
            logic        e;
            // Defaults first, so nothing is latched
            e  = 1'b0;
            c0 = ctl(cfg, m, 0);
            c1 = ctl(cfg, m, 1);
            case (c1[F_OESRC +: 3])
                OE_A:    e = ded_i[OE_PIN_A];
                OE_B:    e = ded_i[OE_PIN_B];
                // A pin enabling itself can loop
                OE_IO:   e = io_in_i[c1[F_OEIDX +: 4]];
                OE_MC:   e = mc_out[c1[F_OEIDX +: 4]];
                OE_PT:   e = res[m].oe_pt;
                OE_ON:   e = 1'b1;
                default: e = 1'b0;
            endcase
            // True or inverted sense
            e = e ^ c1[F_OEINV];
            case (c0[F_IOM +: 2])
                IOM_OUT:   oe[m] = 1'b1;
                IOM_BIDIR: oe[m] = e;
                // Input only; the cell still works inside
                default:   oe[m] = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    // Combinational cells drive pins directly
    // Data shows even when the pin is off
    assign io_out_o = mc_out;
    // Nothing drives until the block runs
    assign io_oe_o  = oe & {N_MC{run_q}};
    // Feedback also goes to other blocks
    assign fb_o     = fb;
endmodule // plm_logic_block

/* File: hw/plm_macrocell.sv */
`timescale 1ns/1ps
module plm_macrocell (
    input  logic                                 clock_i,
    input  logic                                 rst_n_i,
    input  logic [plm_pkg::PTI_W-1:0]            pti_i,
    input  logic [plm_pkg::MC_WORDS*32-1:0]      cfg_i,
    input  logic                                 gclk_i,
    input  logic                                 gclr_i,
    input  logic                                 casc_i,
    input  logic                                 pin_i,
    input  logic                                 run_i,
    output plm_pkg::mc_out_t                     res_o
);
    import plm_pkg::*;
    logic [31:0]      c0, c1;   // Control words
    logic [N_PT-1:0]  pt;       // Product terms
    logic [7:0]       rt;       // Terms gathered by route
    logic [63:0]      tm, cm;   // True and complement masks
    logic             sum, xr, din, ck, ck_q, ce;
    logic             ar, ap, nxt, q_q, rv, latch;
    logic [2:0]       mode, fsel;

    // Terms and their allocation
    always_comb begin
        c0 = cfg_i[31:0];
        c1 = cfg_i[63:32];
        rt = '0;
        pt = '0;
        tm = '0;
        cm = '0;
        for (int p = 0; p < N_PT; p++) begin
            tm = cfg_i[(2+4*p)*32 +: 64];
            cm = cfg_i[(4+4*p)*32 +: 64];
            pt[p] = &((~tm[PTI_W-1:0] | pti_i) &
                      (~cm[PTI_W-1:0] | ~pti_i));
            rt[c0[F_ROUTE+3*p +: 3]] |= pt[p];
        end
    end

    assign mode  = c0[F_MODE +: 3];
    assign latch = (mode == MD_LATCH);
    assign fsel  = c0[F_FOLD +: 3];
    // Five-input sum, chained from the neighbour
    assign sum = rt[RT_SUM] | (c1[F_CASC] & casc_i);
    assign xr  = sum ^ c1[F_XPOL];
    assign din = (c0[F_DSEL +: 2] == DS_PT)  ? rt[RT_DATA] :
                 (c0[F_DSEL +: 2] == DS_PIN) ? pin_i : xr;
    assign ck  = c0[F_CKPT] ? rt[RT_CLK] : gclk_i;
    // Enable only applies with the shared clock
    assign ce  = c0[F_CKPT] | ~c0[F_CE] | rt[RT_CE];
    assign ap  = c0[F_AP] & rt[RT_AP];

    // Reset source choice
    always_comb begin
        case (c0[F_AR +: 2])
            AR_GCLR: ar = gclr_i;
            AR_PT:   ar = rt[RT_AR];
            AR_OR:   ar = gclr_i | rt[RT_AR];
            default: ar = 1'b0;
        endcase
    end

    // Next state per flip-flop kind; aux is K or R
    always_comb begin
        case (mode)
            MD_T:    nxt = q_q ^ din;
            MD_JK:   nxt = (din & ~q_q) | (~rt[RT_AUX] & q_q);
            MD_SR:   nxt = (din & ~rt[RT_AUX]) |
                           (q_q & ~(rt[RT_AUX] & ~din));
            default: nxt = din;
        endcase
    end

    // Clock level history for edge detection
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ck_q <= 1'b0;
        end else begin
            // Tracked while stopped: no false edge at start
            ck_q <= ck;
        end
    end

    // Storage element; clear and preset override
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_q <= 1'b0;
        end else if (!run_i || ar) begin
            q_q <= 1'b0;
        end else if (ap) begin
            q_q <= 1'b1;
        end else if (latch) begin
            if (ck) begin
                q_q <= din;
            end
        end else if (ck && !ck_q && ce) begin
            q_q <= nxt;
        end
    end

    // Transparent path while the latch is open
    assign rv = ar ? 1'b0 : ap ? 1'b1 : (latch & ck) ? din : q_q;

    always_comb begin
        res_o.out   = c0[F_OREG] ? rv : xr;
        res_o.fb    = c0[F_FREG] ? rv : xr;
        res_o.fold  = (fsel < 3'(N_PT)) ? ~pt[fsel] : 1'b1;
        res_o.casc  = sum;
        res_o.oe_pt = rt[RT_OE];
        res_o.q     = rv;
    end
endmodule // plm_macrocell

/* File: hw/plm_pkg.sv */
package plm_pkg;
    // ****************************************
    // Sizes of one logic block
    // ****************************************
    localparam int N_DED    = 4;   // Dedicated input pins
    localparam int N_IO     = 16;  // I/O pins of this block
    localparam int N_MC     = 16;  // Macrocells per block
    localparam int N_SW     = 40;  // Switch matrix outputs
    localparam int N_PT     = 5;   // Product terms per cell
    localparam int EXT_W    = 192; // Other pins and feedbacks
    localparam int SEL_W    = 8;   // Switch select width
    localparam int CASC_LEN = 8;   // Cells per cascade chain
    localparam int PTI_W    = N_SW + N_MC;
    localparam int WORD_W   = 32;
    // ****************************************
    // Configuration store layout (word index)
    // ****************************************
    localparam int SW_BASE   = 0;
    localparam int MC_BASE   = 40;
    localparam int MC_WORDS  = 22; // Two control, twenty mask
    localparam int CFG_DEPTH = MC_BASE + N_MC * MC_WORDS;
    localparam int CFG_AW    = 9;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SIG  = 12'h004;
    localparam logic [11:0] ADDR_OUT  = 12'h008;
    localparam logic [11:0] ADDR_CFG  = 12'h400;
    localparam logic [11:0] ADDR_END  = 12'ha20;
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_FUSE = 1;
    localparam int SIG_W     = 16;
    localparam logic [15:0] SIG_RST = 16'h0000;
    // ****************************************
    // Control word 0 fields (lsb positions)
    // ****************************************
    localparam int F_ROUTE = 0;  // Three bits per term
    localparam int F_FOLD  = 15;
    localparam int F_DSEL  = 18;
    localparam int F_MODE  = 20;
    localparam int F_CKPT  = 23;
    localparam int F_CE    = 24;
    localparam int F_AR    = 25;
    localparam int F_AP    = 27;
    localparam int F_OREG  = 28;
    localparam int F_FREG  = 29;
    localparam int F_IOM   = 30;
    // ****************************************
    // Control word 1 fields (lsb positions)
    // ****************************************
    localparam int F_OESRC  = 0;
    localparam int F_OEINV  = 3;
    localparam int F_OEIDX  = 4;
    localparam int F_XPOL   = 8;
    localparam int F_CASC   = 9;
    localparam int F_CKPIN  = 10;
    localparam int F_CLRPIN = 12;
    localparam int OE_PIN_A = 2; // Dedicated pin used as enable
    localparam int OE_PIN_B = 3;
    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [2:0] RT_SUM = 3'h0, RT_DATA = 3'h1,
        RT_CLK = 3'h2, RT_CE = 3'h3, RT_AR = 3'h4,
        RT_AP = 3'h5, RT_OE = 3'h6, RT_AUX = 3'h7;
    localparam logic [1:0] DS_XOR = 2'h0, DS_PT = 2'h1,
        DS_PIN = 2'h2;
    localparam logic [2:0] MD_D = 3'h0, MD_T = 3'h1,
        MD_JK = 3'h2, MD_SR = 3'h3, MD_LATCH = 3'h4;
    localparam logic [1:0] AR_OFF = 2'h0, AR_GCLR = 2'h1,
        AR_PT = 2'h2, AR_OR = 2'h3;
    localparam logic [1:0] IOM_IN = 2'h0, IOM_OUT = 2'h1,
        IOM_BIDIR = 2'h2;
    localparam logic [2:0] OE_A = 3'h0, OE_B = 3'h1,
        OE_IO = 3'h2, OE_MC = 3'h3, OE_PT = 3'h4,
        OE_ON = 3'h5;
    typedef enum logic [4:0] {
        SEL_CTRL = 5'h01, SEL_SIG = 5'h02, SEL_OUT = 5'h04,
        SEL_CFG = 5'h08, SEL_BAD = 5'h10
    } regsel_t;
    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
    typedef struct packed {
        logic out;   // Pin data
        logic fb;    // Buried feedback
        logic fold;  // Foldback term
        logic casc;  // Cascade to next cell
        logic oe_pt; // Enable product term
        logic q;     // Storage element value
    } mc_out_t;
endpackage
